// ---- csp_pkg.sv ----
package csp_pkg;

    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;

    // printed offsets are register indexes, byte address is four times
    localparam logic [31:0] CLK_CTRL_IDX = 32'h0500000a;
    localparam logic [31:0] PMU_CTRL_IDX = 32'h50000010;
    localparam logic [31:0] OSC_STAT_IDX = 32'h50000014;
    localparam logic [ADDR_W-1:0] CLK_CTRL_ADDR = ADDR_W'(CLK_CTRL_IDX << 2);
    localparam logic [ADDR_W-1:0] PMU_CTRL_ADDR = ADDR_W'(PMU_CTRL_IDX << 2);
    localparam logic [ADDR_W-1:0] OSC_STAT_ADDR = ADDR_W'(OSC_STAT_IDX << 2);

    // clock_source_control fields
    localparam int RUN_XTAL_BIT = 7;
    localparam int RUN_RC_BIT = 6;
    localparam int RUN_SLOW_BIT = 5;
    localparam int FILT_OFF_BIT = 3;
    localparam int XTAL_OFF_BIT = 2;
    localparam int SRC_LSB = 0;

    // power_management_control fields
    localparam int RET_LSB = 8;
    localparam int RET_BANKS = 4;
    localparam int BOOST_BIT = 7;
    localparam int BUCK_BIT = 6;
    localparam int COPY_DIV_LSB = 4;
    localparam int RADIO_PD_BIT = 2;
    localparam int PERIPH_PD_BIT = 1;
    localparam int WAKE_RST_BIT = 0;

    // oscillator status fields
    localparam int SETTLED_BIT = 0;
    localparam int TRIM_DONE_BIT = 1;
    localparam int BOOST_ACT_BIT = 2;
    localparam int BUCK_ACT_BIT = 3;

    // reset values
    localparam logic [1:0] SRC_RST = 2'h0;
    localparam logic [3:0] RET_RST = 4'h0;
    localparam logic [1:0] COPY_DIV_RST = 2'h0;
    localparam logic RADIO_PD_RST = 1'b1;
    localparam logic PERIPH_PD_RST = 1'b1;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing
    localparam int CLK_PERIOD_PS = 5000;
    // settle time in ms; in ps it still fits a 32-bit int
    localparam int SETTLE_TIME_MS = 2;
    localparam int SETTLE_CYCLES_DEF =
        (SETTLE_TIME_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        SRC_FAST_XTAL = 2'b00,
        SRC_FAST_RC = 2'b01,
        SRC_SLOW = 2'b10
    } active_src_t;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_sync import csp_pkg::*; #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;
    logic [W-1:0] stage3_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end else begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // a bit moves only when the last two stages agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncOut <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (stage2_r[i] == stage3_r[i]) begin
                    syncOut[i] <= stage3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- settle_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module settle_timer import csp_pkg::*; #(
    parameter int unsigned CYCLES = SETTLE_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    output logic done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);
    logic [CW-1:0] count_r;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= '0;
        end else if (!run) begin
            count_r <= '0;
        end else if (count_r != LAST) begin
            count_r <= count_r + CW'(1);
        end
    end

    // one cycle past the full count, so strictly more than the time
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
        end else begin
            done <= run && (count_r == LAST);
        end
    end
endmodule
`default_nettype wire

// ---- clock_source_power_ctrl.sv ----
// Overview of operation
// [R01] status bit 7 shows crystal clock, keeps it on
// [R02] status bit 6 shows fast RC clock
// [R03] status bit 5 shows slow oscillator clock
// [R04] bit 3 disables crystal glitch filter
// [R05] bit 2 stops crystal immediately
// [R06] crystal stays off across wakeup
// [R07] software never disables crystal while running on it
// [R08] software waits settled or trimmed before crystal
// [R09] bits 1:0 select crystal, RC or slow
// [R10] bits 11:8 retain or gate four banks
// [R11] bit 7 forces boost at wakeup, wins
// [R12] bit 6 forces buck unless boost set
// [R13] first force write locks both force bits
// [R14] bits 5:4 set mirroring clock division
// [R15] bit 2 powers down radio, resets one
// [R16] bit 1 powers down peripherals, resets one
// [R17] bit 0 resets device after wakeup
// [R18] settled only after over 2 ms
// [R19] trim done when trim applied
// [R20] divider codes divide by 1, 2, 4, 8
`timescale 1ns/10ps
`default_nettype none
module clock_source_power_ctrl import csp_pkg::*; #(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sleepIn,
    input wire logic trimDoneIn,
    input wire logic otpMirrorActive,
    output logic fastCrystalEnable,
    output logic fastCrystalGlitchFilterOff,
    output logic [1:0] systemClockActive,
    output logic [RET_BANKS-1:0] bankPowerGate,
    output logic dcdcBoost,
    output logic dcdcBuck,
    output logic radioPowerdown,
    output logic peripheralPowerdown,
    output logic wakeResetPulse,
    output logic otpCopyClkEn
);

    function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        regHit = (a[ADDR_W-1:2] == r[ADDR_W-1:2]);
    endfunction

    function automatic logic [REG_W-1:0] laneMerge(input logic [REG_W-1:0] old,
                                                   input logic [DATA_W-1:0] d,
                                                   input logic [3:0] s);
        laneMerge = old;
        if (s[0]) begin
            laneMerge[7:0] = d[7:0];
        end
        if (s[1]) begin
            laneMerge[15:8] = d[15:8];
        end
    endfunction

    // code n divides by 2**n, so the terminal count is 2**n - 1
    function automatic logic [2:0] divLast(input logic [1:0] code);
        divLast = 3'((4'h1 << code) - 4'h1); // [R20]
    endfunction

    // bus state
    logic awHeld_r;
    logic [ADDR_W-1:0] awAddr_r;
    logic wHeld_r;
    logic [DATA_W-1:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;
    logic wrClk;
    logic wrPmu;
    logic [REG_W-1:0] clkMerged;
    logic [REG_W-1:0] pmuMerged;

    // register fields
    logic filterOff_r;
    logic crystalOff_r;
    logic [1:0] srcSel_r;
    logic [RET_BANKS-1:0] retMask_r;
    logic forceBoost_r;
    logic forceBuck_r;
    logic forceLock_r;
    logic [1:0] copyDiv_r;
    logic radioPd_r;
    logic periphPd_r;
    logic wakeResetEn_r;

    // block state
    active_src_t activeSrc_r;
    active_src_t activeSrc_nxt;
    logic sleepSync;
    logic trimDoneSync;
    logic sleepPrev_r;
    logic wake;
    logic settled;
    logic [2:0] divCnt_r;
    logic [REG_W-1:0] clkView;
    logic [REG_W-1:0] pmuView;
    logic [REG_W-1:0] statView;

    pin_sync #(
        .W(2)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pinIn({trimDoneIn, sleepIn}),
        .syncOut({trimDoneSync, sleepSync})
    );

    settle_timer #(
        .CYCLES(SETTLE_CYCLES)
    ) u_settle_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(fastCrystalEnable),
        .done(settled) // [R18]
    );

    // write channel: address and data taken in either order
    assign awready = !awHeld_r && !bvalid;
    assign wready = !wHeld_r && !bvalid;
    assign doWrite = awHeld_r && wHeld_r && !bvalid;
    assign wrClk = doWrite && regHit(awAddr_r, CLK_CTRL_ADDR);
    assign wrPmu = doWrite && regHit(awAddr_r, PMU_CTRL_ADDR);
    assign clkMerged = laneMerge(clkView, wData_r, wStrb_r);
    assign pmuMerged = laneMerge(pmuView, wData_r, wStrb_r);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
        end else if (awvalid && awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
        end else if (doWrite) begin
            awHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wHeld_r <= 1'b0;
            wData_r <= '0;
            wStrb_r <= '0;
        end else if (wvalid && wready) begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
        end else if (doWrite) begin
            wHeld_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (wrClk || wrPmu || regHit(awAddr_r, OSC_STAT_ADDR)) ?
                     RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read channel: data one cycle after the address is taken
    assign arready = !rvalid;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            if (regHit(araddr, CLK_CTRL_ADDR)) begin
                rdata <= DATA_W'(clkView);
            end else if (regHit(araddr, PMU_CTRL_ADDR)) begin
                rdata <= DATA_W'(pmuView);
            end else if (regHit(araddr, OSC_STAT_ADDR)) begin
                rdata <= DATA_W'(statView);
            end else begin
                rdata <= '0;
                rresp <= RESP_SLVERR;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // register views, reserved bits read zero
    always_comb begin
        clkView = '0;
        clkView[RUN_XTAL_BIT] = (activeSrc_r == SRC_FAST_XTAL); // [R01]
        clkView[RUN_RC_BIT] = (activeSrc_r == SRC_FAST_RC); // [R02]
        clkView[RUN_SLOW_BIT] = (activeSrc_r == SRC_SLOW); // [R03]
        clkView[FILT_OFF_BIT] = filterOff_r;
        clkView[XTAL_OFF_BIT] = crystalOff_r;
        clkView[SRC_LSB +: 2] = srcSel_r;
    end

    always_comb begin
        pmuView = '0;
        pmuView[RET_LSB +: RET_BANKS] = retMask_r;
        pmuView[BOOST_BIT] = forceBoost_r;
        pmuView[BUCK_BIT] = forceBuck_r;
        pmuView[COPY_DIV_LSB +: 2] = copyDiv_r;
        pmuView[RADIO_PD_BIT] = radioPd_r;
        pmuView[PERIPH_PD_BIT] = periphPd_r;
        pmuView[WAKE_RST_BIT] = wakeResetEn_r;
    end

    always_comb begin
        statView = '0;
        statView[SETTLED_BIT] = settled;
        statView[TRIM_DONE_BIT] = trimDoneSync; // [R19]
        statView[BOOST_ACT_BIT] = dcdcBoost;
        statView[BUCK_ACT_BIT] = dcdcBuck;
    end

    // clock_source_control writable fields
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            filterOff_r <= 1'b0;
            crystalOff_r <= 1'b0;
            srcSel_r <= SRC_RST;
        end else if (wrClk) begin
            filterOff_r <= clkMerged[FILT_OFF_BIT]; // [R04]
            crystalOff_r <= clkMerged[XTAL_OFF_BIT];
            srcSel_r <= clkMerged[SRC_LSB +: 2];
        end
    end

    // power_management_control writable fields
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            retMask_r <= RET_RST;
            copyDiv_r <= COPY_DIV_RST;
            radioPd_r <= RADIO_PD_RST;
            periphPd_r <= PERIPH_PD_RST;
            wakeResetEn_r <= 1'b0;
        end else if (wrPmu) begin
            retMask_r <= pmuMerged[RET_LSB +: RET_BANKS];
            copyDiv_r <= pmuMerged[COPY_DIV_LSB +: 2]; // [R14]
            radioPd_r <= pmuMerged[RADIO_PD_BIT];
            periphPd_r <= pmuMerged[PERIPH_PD_BIT];
            wakeResetEn_r <= pmuMerged[WAKE_RST_BIT];
        end
    end

    // force bits are one-shot: the first write that sets either freezes both
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            forceBoost_r <= 1'b0;
            forceBuck_r <= 1'b0;
            forceLock_r <= 1'b0;
        end else if (wrPmu && !forceLock_r) begin // [R13]
            forceBoost_r <= pmuMerged[BOOST_BIT];
            forceBuck_r <= pmuMerged[BUCK_BIT];
            forceLock_r <= pmuMerged[BOOST_BIT] || pmuMerged[BUCK_BIT]; // [R13]
        end
    end

    // active source; crystal is taken only once it is up and usable
    always_comb begin
        activeSrc_nxt = activeSrc_r;
        case (srcSel_r) // [R09]
            2'b00: begin
                if (fastCrystalEnable && (settled || trimDoneSync)) begin
                    activeSrc_nxt = SRC_FAST_XTAL;
                end
            end
            2'b01: begin
                activeSrc_nxt = SRC_FAST_RC;
            end
            default: begin
                activeSrc_nxt = SRC_SLOW;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            activeSrc_r <= SRC_FAST_XTAL;
        end else begin
            activeSrc_r <= activeSrc_nxt;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            systemClockActive <= SRC_FAST_XTAL;
        end else begin
            systemClockActive <= activeSrc_nxt;
        end
    end

    // off bit acts next edge and persists through sleep; running on it overrides
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fastCrystalEnable <= 1'b1;
        end else begin
            fastCrystalEnable <= !sleepSync &&
                (!crystalOff_r || activeSrc_r == SRC_FAST_XTAL); // [R01] [R05] [R06]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fastCrystalGlitchFilterOff <= 1'b0;
        end else begin
            fastCrystalGlitchFilterOff <= filterOff_r; // [R04]
        end
    end

    // sleep tracking, wake is the fall of the synchronised sleep level
    assign wake = sleepPrev_r && !sleepSync;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleepPrev_r <= 1'b0;
        end else begin
            sleepPrev_r <= sleepSync;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bankPowerGate <= '0;
        end else begin
            bankPowerGate <= sleepSync ? ~retMask_r : '0; // [R10]
        end
    end

    // converter mode only changes at a wakeup
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dcdcBoost <= 1'b0;
            dcdcBuck <= 1'b0;
        end else if (wake) begin
            dcdcBoost <= forceBoost_r; // [R11]
            dcdcBuck <= forceBuck_r && !forceBoost_r; // [R12]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            radioPowerdown <= RADIO_PD_RST;
            peripheralPowerdown <= PERIPH_PD_RST;
        end else begin
            radioPowerdown <= radioPd_r; // [R15]
            peripheralPowerdown <= periphPd_r; // [R16]
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wakeResetPulse <= 1'b0;
        end else begin
            wakeResetPulse <= wake && wakeResetEn_r; // [R17]
        end
    end

    // mirroring clock enable; runs undivided outside mirroring
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt_r <= '0;
            otpCopyClkEn <= 1'b1;
        end else if (!otpMirrorActive) begin
            divCnt_r <= '0;
            otpCopyClkEn <= 1'b1;
        end else if (divCnt_r >= divLast(copyDiv_r)) begin // [R14]
            divCnt_r <= '0;
            otpCopyClkEn <= 1'b1;
        end else begin
            divCnt_r <= divCnt_r + 3'h1;
            otpCopyClkEn <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- clock_source_power_ctrl_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module clock_source_power_ctrl_chk import csp_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic sleepIn,
    input wire logic otpMirrorActive,
    input wire logic fastCrystalEnable,
    input wire logic [1:0] systemClockActive,
    input wire logic [RET_BANKS-1:0] bankPowerGate,
    input wire logic dcdcBoost,
    input wire logic dcdcBuck,
    input wire logic wakeResetPulse,
    input wire logic otpCopyClkEn
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // sync delay of the sleep pin is covered by the eight quiet cycles
    a_xtal_kept_on: assert property ((!sleepIn)[*8] ##1
        (systemClockActive == SRC_FAST_XTAL) |-> fastCrystalEnable)
        else $error("crystal off while it is the active clock");
    a_src_legal: assert property (systemClockActive != 2'h3)
        else $error("active clock code out of range");
    a_awake_ungated: assert property ((!sleepIn)[*8] |-> bankPowerGate == 4'h0)
        else $error("bank gated while awake");
    a_dcdc_exclusive: assert property (!(dcdcBoost && dcdcBuck))
        else $error("boost and buck both active");
    a_wake_single: assert property (wakeResetPulse |=> !wakeResetPulse)
        else $error("wake reset longer than one cycle");
    a_copy_idle: assert property ((!otpMirrorActive)[*2] |-> otpCopyClkEn)
        else $error("copy clock gated outside mirroring");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read data late");
    a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    c_wake: cover property (wakeResetPulse);
    c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
    c_buck: cover property ($rose(dcdcBuck));
endmodule
bind clock_source_power_ctrl clock_source_power_ctrl_chk u_chk (.core_clk, .rst_b,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
    .rdata, .rvalid, .rready, .sleepIn, .otpMirrorActive, .fastCrystalEnable,
    .systemClockActive, .bankPowerGate, .dcdcBoost, .dcdcBuck, .wakeResetPulse,
    .otpCopyClkEn);
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench import csp_pkg::*; ;
    localparam int SETTLE = 20;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} row_t;
    row_t rows [5] = '{'{CLK_CTRL_ADDR, 32'h8, 32'h88, RESP_OKAY},
        '{CLK_CTRL_ADDR, 32'hff00, 32'h80, RESP_OKAY},
        '{PMU_CTRL_ADDR, 32'hf36, 32'hf36, RESP_OKAY},
        '{PMU_CTRL_ADDR, 32'hf000, 32'h0, RESP_OKAY},
        '{8'h60, 32'h1234, 32'h0, RESP_SLVERR}};
    logic core_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
    logic sleepIn, trimDoneIn, otpMirrorActive;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rSeen;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, fastCrystalEnable;
    logic fastCrystalGlitchFilterOff, dcdcBoost, dcdcBuck, radioPowerdown;
    logic peripheralPowerdown, wakeResetPulse, otpCopyClkEn;
    logic [1:0] bresp, rresp, systemClockActive, bResp, rRespSeen;
    logic [RET_BANKS-1:0] bankPowerGate, gateSeen;
    int n_mismatch = 0;
    int checked = 0;
    int cnt;
    clock_source_power_ctrl #(.SETTLE_CYCLES(SETTLE)) u_dut (.core_clk, .rst_b, .awaddr,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .sleepIn,
        .trimDoneIn, .otpMirrorActive, .fastCrystalEnable, .fastCrystalGlitchFilterOff,
        .systemClockActive, .bankPowerGate, .dcdcBoost, .dcdcBuck, .radioPowerdown,
        .peripheralPowerdown, .wakeResetPulse, .otpCopyClkEn);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // handshake flags sampled at the falling edge, so no race with the rising one
    // waits have no timeout, only the watchdog ends a stuck one; the master accepts any latency
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge core_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid & bready;
            bResp = bresp;
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic ta, tr;
        tr = 1'b0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge core_clk);
            ta = arvalid & arready;
            tr = rvalid & rready;
            rSeen = rdata;
            rRespSeen = rresp;
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(rSeen & m, e);
    endtask
    task automatic waitSrc(input logic [1:0] e);
        int n;
        n = 0;
        @(negedge core_clk);
        while (systemClockActive !== e && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        chk(systemClockActive, e);
        @(posedge core_clk);
    endtask
    task automatic reset();
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask
    task automatic nap();
        @(posedge core_clk);
        sleepIn <= 1'b1;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        gateSeen = bankPowerGate;
        @(posedge core_clk);
        sleepIn <= 1'b0;
        cnt = 0;
        repeat (20) begin
            @(negedge core_clk);
            cnt += wakeResetPulse;
        end
    endtask
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        rst_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {sleepIn, trimDoneIn, otpMirrorActive} = 3'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'h3;
        reset();
        @(negedge core_clk);
        chk(fastCrystalEnable, 1'b1);
        chk({radioPowerdown, peripheralPowerdown}, 2'h3);
        chk(systemClockActive, SRC_FAST_XTAL);
        rd(CLK_CTRL_ADDR, 32'hffffffff, 32'h80);
        rd(PMU_CTRL_ADDR, 32'hffffffff, 32'h6);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(bResp, rows[i].r);
            rd(rows[i].a, 32'hffffffff, rows[i].q);
            chk(rRespSeen, rows[i].r);
        end
        @(negedge core_clk);
        chk({radioPowerdown, peripheralPowerdown}, 2'h0);
        for (int d = 0; d < 4; d++) begin
            wr(PMU_CTRL_ADDR, 32'(d) << COPY_DIV_LSB);
            otpMirrorActive <= 1'b1;
            repeat (4) @(posedge core_clk);
            cnt = 0;
            repeat (16) begin
                @(negedge core_clk);
                cnt += otpCopyClkEn;
            end
            chk(cnt, 32'd16 >> d);
            @(posedge core_clk);
            otpMirrorActive <= 1'b0;
        end
        wr(CLK_CTRL_ADDR, 32'h9);
        waitSrc(SRC_FAST_RC);
        chk(fastCrystalGlitchFilterOff, 1'b1);
        rd(CLK_CTRL_ADDR, 32'hffff, 32'h49);
        // crystal is switched off only once it no longer clocks the system
        wr(CLK_CTRL_ADDR, 32'h5);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(fastCrystalEnable, 1'b0);
        chk(fastCrystalGlitchFilterOff, 1'b0);
        wr(CLK_CTRL_ADDR, 32'h7);
        waitSrc(SRC_SLOW);
        rd(CLK_CTRL_ADDR, 32'hffff, 32'h27);
        wr(CLK_CTRL_ADDR, 32'h4);
        repeat (4) @(posedge core_clk);
        rd(CLK_CTRL_ADDR, 32'hffff, 32'h24);
        wr(PMU_CTRL_ADDR, 32'h581);
        nap();
        chk(gateSeen, 4'ha);
        chk(cnt, 1);
        chk({dcdcBoost, dcdcBuck}, 2'h2);
        chk(fastCrystalEnable, 1'b0);
        // retention kept, boost cleared and buck set are both ignored after the lock
        wr(PMU_CTRL_ADDR, 32'h540);
        rd(PMU_CTRL_ADDR, 32'hffff, 32'h580);
        wr(CLK_CTRL_ADDR, 32'h2);
        rd(OSC_STAT_ADDR, 32'h1, 32'h0);
        repeat (SETTLE + 10) @(posedge core_clk);
        rd(OSC_STAT_ADDR, 32'h1, 32'h1);
        // code 00 only after the settled flag is seen
        wr(CLK_CTRL_ADDR, 32'h0);
        waitSrc(SRC_FAST_XTAL);
        rd(CLK_CTRL_ADDR, 32'hffff, 32'h80);
        rd(OSC_STAT_ADDR, 32'h2, 32'h0);
        trimDoneIn <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(OSC_STAT_ADDR, 32'h2, 32'h2);
        reset();
        wr(PMU_CTRL_ADDR, 32'h46);
        nap();
        chk(gateSeen, 4'hf);
        chk(cnt, 0);
        chk({dcdcBoost, dcdcBuck}, 2'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
